/* File: watchdog_sleep_pkg.sv */
/*
 * Shared constants of the watchdog and sleep controller: register offsets,
 * field positions, reset values and timing figures.
 * Assumes a single 40 MHz core clock and a byte-wide register port.
 */
package watchdog_sleep_pkg;

	// register port
	localparam int ADDR_W = 14;
	localparam logic [13:0] OPTION_OFFSET = 14'h0081;
	localparam logic [13:0] CONFIG_OFFSET = 14'h2007;
	localparam logic [13:0] STATUS_OFFSET = 14'h0003;
	localparam logic [13:0] INTCTL_OFFSET = 14'h000B;

	// reset values
	localparam logic [7:0] OPTION_RESET = 8'hFF;
	localparam logic [7:0] CONFIG_BLANK = 8'h00;

	// option register fields
	localparam int OPT_PRESCALER_ASSIGN = 3;
	localparam int OPT_PRESCALE_SELECT_LO = 0;
	localparam int OPT_PRESCALE_SELECT_HI = 2;

	// configuration word fields
	localparam int CFG_WATCHDOG_FUSE_ENABLE = 2;

	// status register fields
	localparam int STS_TIMEOUT_FLAG_N = 4;
	localparam int STS_POWERDOWN_FLAG_N = 3;

	// interrupt control register fields
	localparam int INTCTL_GLOBAL_IRQ_ENABLE = 7;

	// timing
	localparam int CLK_PERIOD_PS = 25_000;
	localparam longint WDT_PERIOD_PS = 64'd18_000_000_000;
	localparam int WDT_BASE_CYCLES = int'(WDT_PERIOD_PS / CLK_PERIOD_PS);
	localparam int OST_OSC_PERIODS = 1024;
	localparam int OST_CYCLES = OST_OSC_PERIODS;
	localparam logic [10:0] OST_LAST = 11'(OST_CYCLES - 1);

	// postscaler
	localparam int POST_W = 7;

	typedef enum logic [1:0] {
		run_st,
		sleep_st,
		osc_start_st
	} mode_e;

endpackage

/* File: watchdog_and_sleep_control.sv */
/*
 * Watchdog timer and power-down (sleep) controller.
 * Assumes inputs are synchronous to mclk, the CPU reports instruction
 * execution as one-cycle pulses, and peripherals supply interrupt flags
 * and their individual enables as levels.
 */
// The implementer's own choice: the address-and-strobe port.
// Operation
// - watchdog runs from its own free-running tick
// - timeout in run mode resets the device
// - timeout in sleep wakes and continues execution
// - cleared fuse bit disables the watchdog permanently
// - nominal timeout 18 ms without postscaler
// - option write assigns postscaler up to 1:128
// - clear or sleep instruction clears counter, postscaler
// - timeout clears the active-low timeout flag
// - sleep entry clears watchdog and power-down flag, sets timeout flag, stops oscillator
// - pins hold their drive state in sleep
// - watchdog reset never drives master clear pin
// - master clear, timeout, enabled interrupt end sleep
// - power-down flag set at power-up, cleared sleeping
// - sleep instruction prefetches the next instruction
// - enabled source wakes regardless of global enable
// - global enable selects in-line resume or vector
// - pending enabled interrupt with global enable off makes sleep a no-op
// - watchdog cleared on every wake from sleep
// - crystal modes wait 1024 oscillator periods after wake
// - global enable is bit 7, cleared on reset
`timescale 1ns/1ps

module watchdog_and_sleep_control #(
	parameter int WDT_BASE_CYCLES = watchdog_sleep_pkg::WDT_BASE_CYCLES,
	parameter int BASE_W = 20,
	parameter int IRQ_N = 10
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// register port
	input wire logic [watchdog_sleep_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// configuration fuses and pins
	input wire logic [7:0] fuse_word,
	input wire logic crystal_mode,
	input wire logic master_clear_pin_n,
	// instruction stream
	input wire logic watchdog_clear_instr,
	input wire logic sleep_instr,
	input wire logic irq_taken,
	// interrupt sources
	input wire logic [IRQ_N-1:0] irq_flag,
	input wire logic [IRQ_N-1:0] irq_enable,
	// controls and status to the core
	output logic watchdog_reset,
	output logic osc_drive_en,
	output logic cpu_stall,
	output logic io_hold,
	output logic prefetch_next,
	output logic sleep_as_nop,
	output logic wake_resume,
	output logic wake_to_vector
);

	localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(WDT_BASE_CYCLES - 1);

	typedef struct packed {
		watchdog_sleep_pkg::mode_e mode;
		logic [BASE_W-1:0] base_cnt;
		logic [watchdog_sleep_pkg::POST_W-1:0] post_cnt;
		logic [7:0] option;
		logic [7:0] fuse;
		logic fuse_loaded;
		logic timeout_flag_n;
		logic powerdown_flag_n;
		logic global_irq_enable;
		logic [10:0] ost_cnt;
		logic wake_gie;
		logic watchdog_reset;
		logic osc_drive_en;
		logic cpu_stall;
		logic io_hold;
		logic prefetch_next;
		logic sleep_as_nop;
		logic wake_resume;
		logic wake_to_vector;
		logic [7:0] rdata;
	} state_s;

	state_s cur;
	state_s next_cur;

	// option and fuse decode
	logic watchdog_fuse_enable;
	logic prescaler_assign;
	logic [2:0] prescale_select;

	// watchdog counter chain
	logic [7:0] post_ratio;
	logic [7:0] post_last;
	logic post_hit;
	logic base_wrap;
	logic timeout;

	// sleep and wake
	logic irq_pending;
	logic sleep_refused;
	logic master_clear;
	logic sleep_timeout;
	logic sleep_irq;
	logic wake;
	logic watchdog_clr;

	always_comb begin
		watchdog_fuse_enable = cur.fuse_loaded && cur.fuse[watchdog_sleep_pkg::CFG_WATCHDOG_FUSE_ENABLE];
		prescaler_assign = cur.option[watchdog_sleep_pkg::OPT_PRESCALER_ASSIGN];
		prescale_select = cur.option[watchdog_sleep_pkg::OPT_PRESCALE_SELECT_HI:
			watchdog_sleep_pkg::OPT_PRESCALE_SELECT_LO];
		// postscale ratio 1:1 unless assigned to the watchdog
		post_ratio = prescaler_assign ? (8'h01 << prescale_select) : 8'h01;
		post_last = post_ratio - 8'h01;
		// at or past the last step, so a lowered ratio never waits for a wrap
		post_hit = {1'b0, cur.post_cnt} >= post_last;
		base_wrap = cur.base_cnt == BASE_LAST;
		timeout = watchdog_fuse_enable && base_wrap && post_hit;
		irq_pending = |(irq_flag & irq_enable);
		// pending enabled source with global enable off refuses sleep
		sleep_refused = !cur.global_irq_enable && irq_pending;
		master_clear = !master_clear_pin_n;
		sleep_timeout = cur.mode == watchdog_sleep_pkg::sleep_st && timeout;
		sleep_irq = cur.mode == watchdog_sleep_pkg::sleep_st && irq_pending;
		wake = sleep_timeout || sleep_irq;
		watchdog_clr = watchdog_clear_instr || sleep_instr || wake;
	end

	always_comb begin
		next_cur = cur;
		next_cur.watchdog_reset = 1'b0;
		next_cur.prefetch_next = 1'b0;
		next_cur.sleep_as_nop = 1'b0;
		next_cur.wake_resume = 1'b0;
		next_cur.wake_to_vector = 1'b0;
		// read data stands one cycle, then reads zero
		next_cur.rdata = 8'h00;

		// configuration word caught once after reset release
		if (!cur.fuse_loaded) begin
			next_cur.fuse = fuse_word;
			next_cur.fuse_loaded = 1'b1;
		end

		// watchdog tick runs whatever the core clock does
		if (watchdog_clr && cur.mode == watchdog_sleep_pkg::run_st) begin
			next_cur.base_cnt = '0;
			next_cur.post_cnt = '0;
		end else if (wake) begin
			next_cur.base_cnt = '0;
			next_cur.post_cnt = '0;
		end else if (base_wrap) begin
			next_cur.base_cnt = '0;
			if (post_hit) begin
				next_cur.post_cnt = '0;
			end else begin
				next_cur.post_cnt = cur.post_cnt + 1'b1;
			end
		end else begin
			next_cur.base_cnt = cur.base_cnt + 1'b1;
		end

		// register port
		if (reg_write) begin
			unique case (reg_addr)
				watchdog_sleep_pkg::OPTION_OFFSET: begin
					next_cur.option = reg_wdata;
				end
				watchdog_sleep_pkg::INTCTL_OFFSET: begin
					next_cur.global_irq_enable = reg_wdata[watchdog_sleep_pkg::INTCTL_GLOBAL_IRQ_ENABLE];
				end
				default: begin
				end
			endcase
		end
		if (reg_read) begin
			unique case (reg_addr)
				watchdog_sleep_pkg::OPTION_OFFSET: begin
					next_cur.rdata = cur.option;
				end
				watchdog_sleep_pkg::CONFIG_OFFSET: begin
					next_cur.rdata = cur.fuse;
				end
				watchdog_sleep_pkg::STATUS_OFFSET: begin
					next_cur.rdata[watchdog_sleep_pkg::STS_TIMEOUT_FLAG_N] = cur.timeout_flag_n;
					next_cur.rdata[watchdog_sleep_pkg::STS_POWERDOWN_FLAG_N] = cur.powerdown_flag_n;
				end
				watchdog_sleep_pkg::INTCTL_OFFSET: begin
					next_cur.rdata[watchdog_sleep_pkg::INTCTL_GLOBAL_IRQ_ENABLE] = cur.global_irq_enable;
				end
				default: begin
					next_cur.rdata = 8'h00;
				end
			endcase
		end

		// interrupt response disables further interrupts
		if (irq_taken) begin
			next_cur.global_irq_enable = 1'b0;
		end

		// sleep state machine
		unique case (cur.mode)
			watchdog_sleep_pkg::run_st: begin
				if (watchdog_clear_instr) begin
					next_cur.timeout_flag_n = 1'b1;
					next_cur.powerdown_flag_n = 1'b1;
				end
				// a clear or sleep in the timeout cycle wins
				if (timeout && !watchdog_clear_instr && !sleep_instr) begin
					// full reset of the core; pin is left alone
					next_cur.watchdog_reset = 1'b1;
					next_cur.timeout_flag_n = 1'b0;
					next_cur.option = watchdog_sleep_pkg::OPTION_RESET;
					next_cur.global_irq_enable = 1'b0;
				end else if (sleep_instr) begin
					next_cur.prefetch_next = 1'b1;
					if (sleep_refused) begin
						next_cur.sleep_as_nop = 1'b1;
					end else begin
						// counts were cleared by the sleep instruction above
						next_cur.mode = watchdog_sleep_pkg::sleep_st;
						next_cur.powerdown_flag_n = 1'b0;
						next_cur.timeout_flag_n = 1'b1;
						next_cur.osc_drive_en = 1'b0;
						next_cur.cpu_stall = 1'b1;
						next_cur.io_hold = 1'b1;
						next_cur.wake_gie = 1'b0;
					end
				end
			end
			watchdog_sleep_pkg::sleep_st: begin
				if (wake) begin
					if (timeout) begin
						next_cur.timeout_flag_n = 1'b0;
					end
					// a timeout wake never branches to the vector
					next_cur.wake_gie = cur.global_irq_enable && !timeout;
					next_cur.io_hold = 1'b0;
					next_cur.osc_drive_en = 1'b1;
					// crystal start-up holds the core for the full wait
					if (crystal_mode) begin
						next_cur.mode = watchdog_sleep_pkg::osc_start_st;
						next_cur.ost_cnt = watchdog_sleep_pkg::OST_LAST;
					end else begin
						next_cur.mode = watchdog_sleep_pkg::run_st;
						next_cur.cpu_stall = 1'b0;
						next_cur.wake_resume = 1'b1;
						next_cur.wake_to_vector = cur.global_irq_enable && !timeout;
					end
				end
			end
			watchdog_sleep_pkg::osc_start_st: begin
				// watchdog keeps running through the start-up wait
				if (timeout) begin
					next_cur.timeout_flag_n = 1'b0;
				end
				if (cur.ost_cnt == 11'h000) begin
					next_cur.mode = watchdog_sleep_pkg::run_st;
					next_cur.cpu_stall = 1'b0;
					next_cur.wake_resume = 1'b1;
					next_cur.wake_to_vector = cur.wake_gie;
				end else begin
					next_cur.ost_cnt = cur.ost_cnt - 11'h001;
				end
			end
			default: begin
				// stray state code falls back to run
				next_cur.mode = watchdog_sleep_pkg::run_st;
				next_cur.cpu_stall = 1'b0;
				next_cur.io_hold = 1'b0;
				next_cur.osc_drive_en = 1'b1;
			end
		endcase

		// external master clear resets the core from any mode
		if (master_clear) begin
			next_cur.mode = watchdog_sleep_pkg::run_st;
			next_cur.option = watchdog_sleep_pkg::OPTION_RESET;
			next_cur.global_irq_enable = 1'b0;
			next_cur.osc_drive_en = 1'b1;
			next_cur.cpu_stall = 1'b0;
			next_cur.io_hold = 1'b0;
			next_cur.wake_resume = 1'b0;
			next_cur.wake_to_vector = 1'b0;
			next_cur.sleep_as_nop = 1'b0;
			next_cur.prefetch_next = 1'b0;
			next_cur.watchdog_reset = 1'b0;
			next_cur.base_cnt = '0;
			next_cur.post_cnt = '0;
			next_cur.ost_cnt = 11'h000;
			next_cur.wake_gie = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cur.mode <= watchdog_sleep_pkg::run_st;
			cur.base_cnt <= '0;
			cur.post_cnt <= '0;
			cur.option <= watchdog_sleep_pkg::OPTION_RESET;
			cur.fuse <= watchdog_sleep_pkg::CONFIG_BLANK;
			cur.fuse_loaded <= 1'b0;
			cur.timeout_flag_n <= 1'b1;
			cur.powerdown_flag_n <= 1'b1;
			cur.global_irq_enable <= 1'b0;
			cur.ost_cnt <= 11'h000;
			cur.wake_gie <= 1'b0;
			cur.watchdog_reset <= 1'b0;
			cur.osc_drive_en <= 1'b1;
			cur.cpu_stall <= 1'b0;
			cur.io_hold <= 1'b0;
			cur.prefetch_next <= 1'b0;
			cur.sleep_as_nop <= 1'b0;
			cur.wake_resume <= 1'b0;
			cur.wake_to_vector <= 1'b0;
			cur.rdata <= 8'h00;
		end else begin
			cur <= next_cur;
		end
	end

	always_comb begin
		reg_rdata = cur.rdata;
		watchdog_reset = cur.watchdog_reset;
		osc_drive_en = cur.osc_drive_en;
		cpu_stall = cur.cpu_stall;
		io_hold = cur.io_hold;
		prefetch_next = cur.prefetch_next;
		sleep_as_nop = cur.sleep_as_nop;
		wake_resume = cur.wake_resume;
		wake_to_vector = cur.wake_to_vector;
	end

endmodule

/* File: watchdog_sleep_checker.sv */
/* concurrent checks on the ports of the watchdog and sleep controller
   assumes one clock mclk and the asynchronous active-high reset */
`timescale 1ns/1ps
module watchdog_sleep_checker #(
	parameter int IRQ_N = 10
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// inputs watched
	input wire logic [7:0] fuse_word,
	input wire logic master_clear_pin_n,
	input wire logic watchdog_clear_instr,
	input wire logic sleep_instr,
	input wire logic [IRQ_N-1:0] irq_flag,
	input wire logic [IRQ_N-1:0] irq_enable,
	// outputs watched
	input wire logic watchdog_reset,
	input wire logic osc_drive_en,
	input wire logic cpu_stall,
	input wire logic io_hold,
	input wire logic prefetch_next,
	input wire logic sleep_as_nop,
	input wire logic wake_resume,
	input wire logic wake_to_vector
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	wdt_pulse_a: assert property (watchdog_reset |=> !watchdog_reset) else $error("reset pulse too long");
	fuse_off_a: assert property (!fuse_word[2] && $stable(fuse_word) |-> !watchdog_reset)
		else $error("reset with fuse clear");
	clear_hold_a: assert property (watchdog_clear_instr |=> !watchdog_reset [*8])
		else $error("reset soon after clear");
	sleep_fetch_a: assert property (sleep_instr && !cpu_stall && master_clear_pin_n |=> prefetch_next)
		else $error("no prefetch after sleep");
	sleep_enter_a: assert property ($rose(io_hold) |-> !osc_drive_en && cpu_stall)
		else $error("sleep entry levels wrong");
	nop_stay_a: assert property (sleep_as_nop |-> !io_hold && !cpu_stall) else $error("slept on refusal");
	vector_pair_a: assert property (wake_to_vector |-> wake_resume) else $error("vector without resume");
	sleep_no_reset_a: assert property (io_hold |-> !watchdog_reset) else $error("reset while asleep");
	irq_wake_a: assert property (io_hold && (|(irq_flag & irq_enable)) |=> !io_hold)
		else $error("no wake on enabled irq");
	master_clear_pin_wake_a: assert property (!master_clear_pin_n |=> !io_hold) else $error("no wake on master clear");
endmodule
bind watchdog_and_sleep_control watchdog_sleep_checker #(.IRQ_N(IRQ_N)) i_chk (.mclk(mclk), .reset(reset),
	.fuse_word(fuse_word), .master_clear_pin_n(master_clear_pin_n), .watchdog_clear_instr(watchdog_clear_instr),
	.sleep_instr(sleep_instr), .irq_flag(irq_flag), .irq_enable(irq_enable), .watchdog_reset(watchdog_reset),
	.osc_drive_en(osc_drive_en), .cpu_stall(cpu_stall), .io_hold(io_hold), .prefetch_next(prefetch_next),
	.sleep_as_nop(sleep_as_nop), .wake_resume(wake_resume), .wake_to_vector(wake_to_vector));

/* File: watchdog_and_sleep_control_tb.sv */
/* self-checking bench for the watchdog and sleep controller
   assumes a shortened base count of 16 cycles and the package offsets */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module watchdog_and_sleep_control_tb;
	localparam logic [13:0] OPT = watchdog_sleep_pkg::OPTION_OFFSET;
	localparam logic [13:0] CFG = watchdog_sleep_pkg::CONFIG_OFFSET;
	localparam logic [13:0] STS = watchdog_sleep_pkg::STATUS_OFFSET;
	localparam logic [13:0] ICT = watchdog_sleep_pkg::INTCTL_OFFSET;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [13:0] reg_addr = 14'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] fuse_word = 8'h04;
	logic crystal_mode = 1'b0;
	logic master_clear_pin_n = 1'b1;
	logic watchdog_clear_instr = 1'b0;
	logic sleep_instr = 1'b0;
	logic irq_taken = 1'b0;
	logic [9:0] irq_flag = 10'h000;
	logic [9:0] irq_enable = 10'h000;
	logic [7:0] reg_rdata;
	logic watchdog_reset, osc_drive_en, cpu_stall, io_hold, prefetch_next, sleep_as_nop, wake_resume, wake_to_vector;
	logic [7:0] d;
	logic vec;
	logic [4:0] snap;
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;
	int n;
	int r;
	watchdog_and_sleep_control #(.WDT_BASE_CYCLES(16)) i_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.fuse_word(fuse_word), .crystal_mode(crystal_mode), .master_clear_pin_n(master_clear_pin_n),
		.watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr), .irq_taken(irq_taken),
		.irq_flag(irq_flag), .irq_enable(irq_enable), .watchdog_reset(watchdog_reset), .osc_drive_en(osc_drive_en),
		.cpu_stall(cpu_stall), .io_hold(io_hold), .prefetch_next(prefetch_next), .sleep_as_nop(sleep_as_nop),
		.wake_resume(wake_resume), .wake_to_vector(wake_to_vector));
	always #12.5 mclk = ~mclk;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic wr(input logic [13:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [13:0] a);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
		@(posedge mclk);
	endtask
	// 0 clear, 1 sleep, 2 interrupt taken
	task automatic instr(input int k);
		if (k == 0) watchdog_clear_instr <= 1'b1;
		else if (k == 1) sleep_instr <= 1'b1;
		else irq_taken <= 1'b1;
		@(posedge mclk);
		watchdog_clear_instr <= 1'b0;
		sleep_instr <= 1'b0;
		irq_taken <= 1'b0;
		@(negedge mclk);
		snap = {prefetch_next, sleep_as_nop, io_hold, osc_drive_en, cpu_stall};
		@(posedge mclk);
	endtask
	// cycles until watchdog reset (w=0) or wake (w=1), 3000 at most
	task automatic cnt_until(input bit w);
		n = 0;
		@(negedge mclk);
		while (n < 3000 && (w ? wake_resume : watchdog_reset) !== 1'b1) begin
			@(negedge mclk);
			n++;
		end
		vec = wake_to_vector;
		@(posedge mclk);
	endtask
	task automatic go_reset(input logic [7:0] f);
		reset <= 1'b1;
		fuse_word <= f;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	initial begin
		go_reset(8'h04);
		rd(OPT); `CHK(d, 8'hFF)
		rd(STS); `CHK(d[4:3], 2'b11)
		rd(ICT); `CHK(d[7], 1'b0)
		rd(14'h0040); `CHK(d, 8'h00)
		wr(CFG, 8'hFF); rd(CFG); `CHK(d, 8'h04)
		wr(ICT, 8'h80); rd(ICT); `CHK(d[7], 1'b1)
		$display("test registers done");
		for (int s = 0; s < 9; s++) begin
			r = (s == 8) ? 1 : (1 << s);
			wr(OPT, (s == 8) ? 8'h00 : 8'(8 + s));
			instr(0);
			cnt_until(0);
			`CHK(n >= 16 * r - 2 && n <= 16 * r + 2, 1'b1)
			rd(STS); `CHK(d[4], 1'b0)
		end
		wr(OPT, 8'h00);
		repeat (12) instr(0);
		rd(STS); `CHK(d[4], 1'b1)
		$display("test period done");
		instr(1);
		`CHK(snap, 5'b10101)
		rd(STS); `CHK(d[4:3], 2'b10)
		cnt_until(1); `CHK(n <= 20, 1'b1)
		`CHK(vec, 1'b0)
		rd(STS); `CHK(d[4], 1'b0)
		$display("test timeout wake done");
		wr(OPT, 8'hFF); wr(ICT, 8'h80);
		irq_flag <= 10'h008;
		instr(1);
		repeat (20) @(posedge mclk);
		`CHK(io_hold, 1'b1)
		irq_enable <= 10'h008;
		cnt_until(1); `CHK(n <= 4, 1'b1)
		`CHK(vec, 1'b1)
		instr(2); rd(ICT); `CHK(d[7], 1'b0)
		instr(1); `CHK(snap[3:2], 2'b10)
		$display("test irq wake done");
		irq_enable <= 10'h000;
		crystal_mode <= 1'b1;
		instr(1);
		irq_enable <= 10'h008;
		cnt_until(1); `CHK(n >= 1020 && n <= 1032, 1'b1)
		`CHK(vec, 1'b0)
		irq_enable <= 10'h000;
		crystal_mode <= 1'b0;
		wr(OPT, 8'h00);
		instr(1); `CHK(io_hold, 1'b1)
		master_clear_pin_n <= 1'b0;
		@(posedge mclk);
		master_clear_pin_n <= 1'b1;
		@(posedge mclk);
		`CHK({io_hold, cpu_stall}, 2'b00)
		rd(OPT); `CHK(d, 8'hFF)
		$display("test crystal and master clear done");
		go_reset(8'h00);
		cnt_until(0); `CHK(n, 3000)
		$display("test fuse off done");
		report_and_stop();
	end
endmodule
